// *** verification/lcd_bias_sva.sv ***
`timescale 1ns/1ps
module lcd_bias_sva
  import lcd_bias_pkg::*;
#(
  parameter int unsigned CYCLES_PER_MS_P = CYCLES_PER_MS
) (
  // clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  // supply and rails
  input wire logic        input_ok_i,
  input wire logic        pos_pump_short_i,
  input wire logic        logic_regulator_en_o,
  input wire rail_en_type rail_en_o,
  input wire logic        boost_switch_en_o,
  input wire logic        reset_n_out_o,
  input wire logic        reset_n_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // bus answers exactly one cycle after a new request
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged in one cycle");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  // open drain pin only ever pulls low
  a_reset_pin_low: assert property (reset_n_out_o == 1'b0)
    else $error("reset pin data not low");
  // idle keeps the panel controller in reset
  a_idle_reset: assert property (!logic_regulator_en_o [*2] |-> reset_n_oe_o)
    else $error("reset released while idle");
  a_neg_release: assert property ($rose(rail_en_o.neg_pump) |-> $fell(reset_n_oe_o))
    else $error("negative pump and reset release not together");
  a_boost_order: assert property ($rose(rail_en_o.boost) |-> rail_en_o.neg_pump && !reset_n_oe_o)
    else $error("boost enabled before negative pump");
  a_pos_order: assert property ($rose(rail_en_o.pos_pump) |-> rail_en_o.boost)
    else $error("positive pump enabled before boost");
  a_shifter_order: assert property ($rose(rail_en_o.shifter) |-> rail_en_o.pos_pump)
    else $error("shifter enabled before positive pump");
  // two sync flops plus the register give the margin
  a_uv_all_off: assert property (!input_ok_i [*5] |-> rail_en_o[5:1] == 5'h00)
    else $error("rails still enabled after supply loss");
  a_short_halt: assert property (pos_pump_short_i [*4] |-> !boost_switch_en_o)
    else $error("boost switching during pump short");
endmodule : lcd_bias_sva

bind lcd_bias_power_sequencer lcd_bias_sva #(.CYCLES_PER_MS_P(CYCLES_PER_MS_P)) sva (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .input_ok_i(input_ok_i), .pos_pump_short_i(pos_pump_short_i),
  .logic_regulator_en_o(logic_regulator_en_o), .rail_en_o(rail_en_o),
  .boost_switch_en_o(boost_switch_en_o), .reset_n_out_o(reset_n_out_o),
  .reset_n_oe_o(reset_n_oe_o));

// *** verification/power_stage_model.sv ***
`timescale 1ns/1ps
module power_stage_model
  import lcd_bias_pkg::*;
(
  // clock, enables and ramp length
  input  wire logic        clk_i,
  input  wire rail_en_type rail_en_i,
  input  wire logic [2:0]  lag_i,
  // power goods and gate high comparators
  output logic             pgb_o,
  output logic             pgn_o,
  output logic             pg_o,
  output logic             gh_on_o,
  output logic             gh_uv_o
);
  logic [7:0] buck_sr, neg_sr, boost_sr, pos_sr;

  // rails ramp for lag_i+1 cycles and decay as slowly after disable
  always_ff @(posedge clk_i) begin
    buck_sr  <= {buck_sr[6:0], rail_en_i.logic_buck};
    neg_sr   <= {neg_sr[6:0], rail_en_i.neg_pump};
    boost_sr <= {boost_sr[6:0], rail_en_i.boost};
    pos_sr   <= {pos_sr[6:0], rail_en_i.pos_pump};
  end
  assign pgb_o   = buck_sr[lag_i];
  assign pgn_o   = neg_sr[lag_i];
  assign pg_o    = boost_sr[lag_i];
  assign gh_on_o = pos_sr[lag_i];
  // gate high stays above shifter level until fully decayed
  assign gh_uv_o = |pos_sr;
endmodule : power_stage_model

// *** verification/tb_lcd_bias_power_sequencer.sv ***
`timescale 1ns/1ps
module tb_lcd_bias_power_sequencer;
  import lcd_bias_pkg::*;
  localparam int CPM = 10;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic        ack_o, reg_en, bsw, rno, roe, logic_buck_power_good, negative_pump_power_good, pg, gh_on, gh_uv;
  logic        input_ok_i = 1'b0, short = 1'b0;
  logic [2:0]  lag = 3'h1;
  rail_en_type rail_en_o;
  trim_type    trim_o;
  logic [53:0] gamma;
  int          err_count = 0, checked = 0;

  always #2.5 clk_i = ~clk_i;

  lcd_bias_power_sequencer #(.CYCLES_PER_MS_P(CPM)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .input_ok_i(input_ok_i),
    .logic_buck_power_good_i(logic_buck_power_good), .negative_pump_power_good_i(negative_pump_power_good),
    .boost_power_good_i(pg), .gate_high_above_on_i(gh_on),
    .gate_high_above_shifter_uv_i(gh_uv), .pos_pump_short_i(short),
    .logic_regulator_en_o(reg_en), .rail_en_o(rail_en_o), .boost_switch_en_o(bsw),
    .reset_n_out_o(rno), .reset_n_oe_o(roe), .trim_o(trim_o), .gamma_reference_o(gamma));
  power_stage_model stage (.clk_i(clk_i), .rail_en_i(rail_en_o), .lag_i(lag), .pgb_o(logic_buck_power_good),
    .pgn_o(negative_pump_power_good), .pg_o(pg), .gh_on_o(gh_on), .gh_uv_o(gh_uv));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_rng(input int n, input int lo, input int hi);
    checked++;
    if (n < lo || n > hi) begin
      err_count++;
      $display("ERROR %0t wait %0d outside %0d..%0d", $time, n, lo, hi);
    end
  endtask : chk_rng
  // classic cycle; ack and read data taken at the rising edge that sees ack high
  task automatic wb(input logic w, input int a, input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, 8'(a), d, s};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    r = dat_o;
    if (n >= 50) begin
      err_count++;
      $display("ERROR %0t bus ack timeout", $time);
    end
    {cyc_i, stb_i} <= 2'b00;
  endtask : wb
  task automatic wait_en(input int b, output int n);
    n = 0;
    while (rail_en_o[b] !== 1'b1 && n < 2000) begin
      @(negedge clk_i);
      n++;
    end
  endtask : wait_en
  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  initial begin
    #200000;
    err_count++;
    print_verdict();
  end

  initial begin
    logic [31:0] r;
    logic [11:0] v[10];
    int n, e;
    void'($urandom(32'hE655F4E4));
    lag <= 3'($urandom_range(1, 7));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, 0, 32'hFFFF_FFFF, 4'h1, r);
    wb(1'b0, 0, 32'h0, 4'hF, r);
    chk(r, 64'h0FF);
    wb(1'b1, 8'h40, 32'hFFFF_FFFF, 4'hF, r);
    wb(1'b0, 8'h40, 32'h0, 4'hF, r);
    chk(r, 64'h0);
    for (int i = 0; i < 10; i++) begin
      v[i] = (i < 3) ? 12'($urandom) : 12'($urandom & 32'h1FF);
      wb(1'b1, 4 * i, {20'h0, v[i]}, 4'hF, r);
    end
    for (int i = 0; i < 10; i++) begin
      wb(1'b0, 4 * i, 32'h0, 4'hF, r);
      chk(r, v[i]);
    end
    for (int i = 0; i < 6; i++) chk(gamma[9*i+:9], v[4+i]);
    chk(trim_o, {v[1][5:0], v[1][6], v[1][7], v[1][11:8], v[2][3:0], v[2][7:4], v[2][11:8],
                 v[3][2:0], v[3][6:3], v[3][8:7]});
    // power up walk; each delay wait counted against its programmed code, the shifter wait against lag
    @(posedge clk_i);
    input_ok_i <= 1'b1;
    wait_en(5, n);
    e = (v[0][2:0] + 1) * 3 * CPM;
    chk_rng(n, e - 2, e + 6);
    chk(roe, 1'b1);
    chk(reg_en, 1'b1);
    n = 0;
    while (roe !== 1'b0 && n < 2000) begin
      @(negedge clk_i);
      n++;
    end
    e = v[0][5:3] * 5 * CPM + lag;
    chk_rng(n, e - 1, e + 8);
    chk(rail_en_o.neg_pump, 1'b1);
    for (int k = 2; k < 4; k++) begin
      wait_en(5 - 2 * (k - 1), n);
      e = v[0][3*k+:3] * 5 * CPM;
      chk_rng(n, e - 2, ((e > lag) ? e : lag) + 8);
    end
    chk(rail_en_o.track_buck, 1'b1);
    wait_en(0, n);
    chk_rng(n, 0, lag + 8);
    // pump short halts boost switching without latching
    @(posedge clk_i);
    short <= 1'b1;
    repeat (4) @(negedge clk_i);
    chk(bsw, 1'b0);
    @(posedge clk_i);
    short <= 1'b0;
    repeat (4) @(negedge clk_i);
    chk(bsw, 1'b1);
    @(posedge clk_i);
    input_ok_i <= 1'b0;
    repeat (5) @(negedge clk_i);
    chk(rail_en_o[5:1], 5'h00);
    chk(rail_en_o.shifter, 1'b1);
    chk({roe, reg_en}, 2'b10);
    n = 0;
    while (rail_en_o.shifter !== 1'b0 && n < 50) begin
      @(negedge clk_i);
      n++;
    end
    chk_rng(n, 1, 20);
    print_verdict();
  end
endmodule : tb_lcd_bias_power_sequencer

// *** verilog/lcd_bias_pkg.sv ***
package lcd_bias_pkg;

  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned STEP_FIRST_MS   = 3;
  localparam int unsigned STEP_LATER_MS   = 5;
  localparam int unsigned MS_PER_S        = 1000;
  localparam int unsigned CYCLES_PER_MS   = CLK_HZ / MS_PER_S;

  // register map, word offsets as byte addresses
  localparam logic [7:0] ADDR_DELAY   = 8'h00;
  localparam logic [7:0] ADDR_RAILS   = 8'h04;
  localparam logic [7:0] ADDR_GATE    = 8'h08;
  localparam logic [7:0] ADDR_COMMON  = 8'h0C;
  localparam logic [7:0] ADDR_GAMMA0  = 8'h10;
  localparam logic [7:0] ADDR_GAMMA5  = 8'h24;
  localparam logic [7:0] ADDR_STATUS  = 8'h28;

  // reset values of programmable codes
  localparam logic [11:0] DELAY_RESET  = 12'h000;
  localparam logic [11:0] RAILS_RESET  = 12'h000;
  localparam logic [11:0] GATE_RESET   = 12'h000;
  localparam logic [8:0]  COMMON_RESET = 9'h000;
  localparam logic [8:0]  GAMMA_RESET  = 9'h000;

  typedef enum logic [2:0] {
    SEQ_IDLE      = 3'b000,
    SEQ_FIRST     = 3'b001,
    SEQ_WAIT_PGB  = 3'b011,
    SEQ_SECOND    = 3'b010,
    SEQ_THIRD     = 3'b110,
    SEQ_FOURTH    = 3'b111,
    SEQ_RUN       = 3'b101
  } seq_state_type;

  // rail enables out of the sequencer
  typedef struct packed {
    logic logic_buck;
    logic neg_pump;
    logic boost;
    logic track_buck;
    logic pos_pump;
    logic shifter;
  } rail_en_type;

  // programmable analog codes
  typedef struct packed {
    logic [5:0] boost_code;
    logic       boost_fast;
    logic       buck_fast;
    logic [3:0] buck_code;
    logic [3:0] gh_low_temp;
    logic [3:0] gh_high_temp;
    logic [3:0] gate_low_code;
    logic [2:0] common_gain;
    logic [3:0] common_temp_offset;
    logic [1:0] common_temp_window;
  } trim_type;

endpackage : lcd_bias_pkg

// *** verilog/lcd_bias_power_sequencer.sv ***
`timescale 1ns/1ps
module lcd_bias_power_sequencer
  import lcd_bias_pkg::*;
#(
  parameter int unsigned CYCLES_PER_MS_P = CYCLES_PER_MS,
  parameter int unsigned GAMMA_CH        = 6
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic [31:0]            dat_o,
  output logic                   ack_o,
  // analog comparators and power goods
  input  wire logic              input_ok_i,
  input  wire logic              logic_buck_power_good_i,
  input  wire logic              negative_pump_power_good_i,
  input  wire logic              boost_power_good_i,
  input  wire logic              gate_high_above_on_i,
  input  wire logic              gate_high_above_shifter_uv_i,
  input  wire logic              pos_pump_short_i,
  // rail controls
  output logic                   logic_regulator_en_o,
  output rail_en_type            rail_en_o,
  output logic                   boost_switch_en_o,
  output logic                   reset_n_out_o,
  output logic                   reset_n_oe_o,
  output trim_type               trim_o,
  output logic [GAMMA_CH*9-1:0]  gamma_reference_o
);

  localparam int unsigned TW = 26;
  localparam logic [TW-1:0] MS_CYC = TW'(CYCLES_PER_MS_P);

  // two-flop synchronisers for the analog inputs
  localparam int unsigned NS = 7;
  logic [NS-1:0] meta_reg;
  logic [NS-1:0] sync_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= {input_ok_i, logic_buck_power_good_i, negative_pump_power_good_i,
                   boost_power_good_i, gate_high_above_on_i,
                   gate_high_above_shifter_uv_i, pos_pump_short_i};
      sync_reg <= meta_reg;
    end
  end
  logic vin_ok, logic_buck_power_good, negative_pump_power_good, pg, gh_on, gh_uv_ok, pos_short;
  assign {vin_ok, logic_buck_power_good, negative_pump_power_good, pg, gh_on, gh_uv_ok, pos_short} = sync_reg;

  // programmable registers
  logic [11:0] delay_reg;
  logic [11:0] rails_reg;
  logic [11:0] gate_reg;
  logic [8:0]  common_reg;
  logic [8:0]  gamma_reg [GAMMA_CH];

  logic wr_stb;
  assign wr_stb = cyc_i & stb_i & we_i & ~ack_o;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) res[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return res;
  endfunction : merge

  // code registers steering the sequencer and trims
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      delay_reg  <= DELAY_RESET;
      rails_reg  <= RAILS_RESET;
      gate_reg   <= GATE_RESET;
      common_reg <= COMMON_RESET;
    end else if (wr_stb) begin
      case (adr_i)
        ADDR_DELAY:  delay_reg  <= 12'(merge({20'h0, delay_reg}, dat_i, sel_i));
        ADDR_RAILS:  rails_reg  <= 12'(merge({20'h0, rails_reg}, dat_i, sel_i));
        ADDR_GATE:   gate_reg   <= 12'(merge({20'h0, gate_reg}, dat_i, sel_i));
        ADDR_COMMON: common_reg <= 9'(merge({23'h0, common_reg}, dat_i, sel_i));
        default: ;
      endcase
    end
  end

  // gamma codes, one word each
  for (genvar g = 0; g < GAMMA_CH; g++) begin : g_gamma
    localparam logic [7:0] ADDR_G = ADDR_GAMMA0 + 8'(4 * g);
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        gamma_reg[g] <= GAMMA_RESET;
      end else if (wr_stb && adr_i == ADDR_G) begin
        gamma_reg[g] <= 9'(merge({23'h0, gamma_reg[g]}, dat_i, sel_i));
      end
    end
    assign gamma_reference_o[g*9 +: 9] = gamma_reg[g];
  end

  assign trim_o = '{boost_code:        rails_reg[5:0],
                    boost_fast:        rails_reg[6],
                    buck_fast:         rails_reg[7],
                    buck_code:         rails_reg[11:8],
                    gh_low_temp:       gate_reg[3:0],
                    gh_high_temp:      gate_reg[7:4],
                    gate_low_code:     gate_reg[11:8],
                    common_gain:       common_reg[2:0],
                    common_temp_offset: common_reg[6:3],
                    common_temp_window: common_reg[8:7]};

  // sequencer
  seq_state_type state_reg;
  logic [TW-1:0] ms_cnt_reg;
  logic [5:0]    ms_left_reg;
  logic          delay_done;
  rail_en_type   en_reg;
  logic          rst_low_reg;

  // delay targets in ms: first is (code+1)*3, others code*5
  logic [5:0] first_ms, second_ms, third_ms, fourth_ms;
  assign first_ms  = 6'((delay_reg[2:0] + 4'h1) * STEP_FIRST_MS);
  assign second_ms = 6'(delay_reg[5:3]  * STEP_LATER_MS);
  assign third_ms  = 6'(delay_reg[8:6]  * STEP_LATER_MS);
  assign fourth_ms = 6'(delay_reg[11:9] * STEP_LATER_MS);

  assign delay_done = (ms_left_reg == 6'h00);

  // millisecond prescaler and down counter; loaded on entry to SEQ_FIRST, SEQ_SECOND, SEQ_THIRD and SEQ_FOURTH
  logic load_delay;
  logic [5:0] load_ms;
  always_ff @(posedge clk_i) begin
    if (rst_i || !vin_ok) begin
      ms_cnt_reg  <= '0;
      ms_left_reg <= '0;
    end else if (load_delay) begin
      ms_cnt_reg  <= '0;
      ms_left_reg <= load_ms;
    end else if (!delay_done) begin
      if (ms_cnt_reg == MS_CYC - TW'(1)) begin
        ms_cnt_reg  <= '0;
        ms_left_reg <= ms_left_reg - 6'h01;
      end else begin
        ms_cnt_reg <= ms_cnt_reg + TW'(1);
      end
    end
  end

  // state transitions
  always_comb begin
    load_delay = 1'b0;
    load_ms    = '0;
    case (state_reg)
      SEQ_IDLE:     begin load_delay = vin_ok;        load_ms = first_ms;  end
      SEQ_WAIT_PGB: begin load_delay = logic_buck_power_good;           load_ms = second_ms; end
      SEQ_SECOND:   begin load_delay = delay_done;    load_ms = third_ms;  end
      SEQ_THIRD:    begin load_delay = delay_done & negative_pump_power_good; load_ms = fourth_ms; end
      default:      ;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !vin_ok) begin
      state_reg   <= SEQ_IDLE;
      en_reg      <= '0;
      rst_low_reg <= 1'b0;
    end else begin
      case (state_reg)
        SEQ_IDLE: begin
          state_reg   <= SEQ_FIRST;
          rst_low_reg <= 1'b1;
        end
        SEQ_FIRST: if (delay_done) begin
          en_reg.logic_buck <= 1'b1;
          state_reg         <= SEQ_WAIT_PGB;
        end
        SEQ_WAIT_PGB: if (logic_buck_power_good) begin
          state_reg <= SEQ_SECOND;
        end
        SEQ_SECOND: if (delay_done) begin
          rst_low_reg     <= 1'b0;
          en_reg.neg_pump <= 1'b1;
          state_reg       <= SEQ_THIRD;
        end
        SEQ_THIRD: if (delay_done && negative_pump_power_good) begin
          en_reg.boost      <= 1'b1;
          en_reg.track_buck <= 1'b1;
          state_reg         <= SEQ_FOURTH;
        end
        SEQ_FOURTH: if (delay_done && pg) begin
          en_reg.pos_pump <= 1'b1;
          state_reg       <= SEQ_RUN;
        end
        SEQ_RUN: ;
        default: state_reg <= SEQ_IDLE;
      endcase
      // shifter follows gate high rail with hysteresis
      if (en_reg.pos_pump && gh_on)
        en_reg.shifter <= 1'b1;
      else if (!gh_uv_ok)
        en_reg.shifter <= 1'b0;
    end
  end

  // the shifter stays up past undervoltage until gate high decays; kept in own flop
  logic shifter_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) shifter_reg <= 1'b0;
    else if (en_reg.shifter) shifter_reg <= 1'b1;
    else if (!gh_uv_ok) shifter_reg <= 1'b0;
  end

  // outputs
  logic boost_sw_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) boost_sw_reg <= 1'b0;
    else boost_sw_reg <= en_reg.boost & vin_ok & ~pos_short;
  end

  always_comb begin
    rail_en_o         = en_reg;
    rail_en_o.shifter = shifter_reg;
  end
  assign boost_switch_en_o    = boost_sw_reg;
  assign logic_regulator_en_o = (state_reg != SEQ_IDLE);
  // open drain: pull low while reset asserted, idle or supply absent;
  // idle term covers the one cycle before rst_low_reg is set
  assign reset_n_out_o = 1'b0;
  assign reset_n_oe_o  = rst_low_reg | ~vin_ok | (state_reg == SEQ_IDLE);

  // wishbone read and ack, registered, ack one cycle after the request
  logic [31:0] rd_data;
  always_comb begin
    rd_data = '0;
    case (adr_i)
      ADDR_DELAY:  rd_data = {20'h0, delay_reg};
      ADDR_RAILS:  rd_data = {20'h0, rails_reg};
      ADDR_GATE:   rd_data = {20'h0, gate_reg};
      ADDR_COMMON: rd_data = {23'h0, common_reg};
      ADDR_STATUS: rd_data = {20'h0, 3'(state_reg), rst_low_reg, rail_en_o, pos_short, vin_ok};
      default: begin
        for (int i = 0; i < GAMMA_CH; i++) begin
          if (adr_i == ADDR_GAMMA0 + 8'(4 * i)) rd_data = {23'h0, gamma_reg[i]};
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      dat_o <= rd_data;
    end
  end

endmodule : lcd_bias_power_sequencer
